// [dv/tb.sv]
// Purpose: directed bench for the oscillator warm-up counter
// Assumes: oscillator pins made from clk, far below clk/2
// Notes:   warm-up lengths are measured in oscillator rising edges
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wu_pkg::*;
  logic        clk, srst, fast_osc_clock, slow_osc_clock;
  logic        stop_enter_pulse, stop_wake_pulse, main_clk_is_slow;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd, sys2, v;
  logic        cpu_periph_reset, stop_resume_pulse, warmup_done_irq;
  logic        fast_osc_run, slow_osc_run;
  logic [2:0]  ph;
  int          bad_count, checks_done, fe, se, irq_n, res_n, cyc, i0, e0;

  wu_warmup_counter DUT (.clk(clk), .srst(srst),
    .fast_osc_clock(fast_osc_clock), .slow_osc_clock(slow_osc_clock),
    .stop_enter_pulse(stop_enter_pulse), .stop_wake_pulse(stop_wake_pulse),
    .main_clk_is_slow(main_clk_is_slow), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_periph_reset(cpu_periph_reset),
    .stop_resume_pulse(stop_resume_pulse),
    .warmup_done_irq(warmup_done_irq), .fast_osc_run(fast_osc_run),
    .slow_osc_run(slow_osc_run));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // *****************************************
  // oscillators stand still while not enabled
  // *****************************************
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    cyc <= cyc + 1;
    if (ph[0]) fast_osc_clock <= fast_osc_run & ~fast_osc_clock;
    if (ph[1:0] == 2'h3) slow_osc_clock <= slow_osc_run & ~slow_osc_clock;
    if (ph[0] && fast_osc_run && !fast_osc_clock) fe <= fe + 1;
    if (ph[1:0] == 2'h3 && slow_osc_run && !slow_osc_clock) se <= se + 1;
    if (warmup_done_irq === 1'b1) irq_n <= irq_n + 1;
    if (stop_resume_pulse === 1'b1) res_n <= res_n + 1;
    if (cyc == 40000) begin
      $display("unexpected at %0t: run timed out", $time);
      bad_count++;
      finish_test();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input int got, input int exp);
    checks_done++;
    if (got < exp - 8 || got > exp + 8) begin
      bad_count++;
      $display("unexpected at %0t: %0d edges, want %0d", $time, got, exp);
    end
  endtask : near
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
    chk(32'(n < 50), 32'h1);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic pulse(input bit wake);
    if (wake) stop_wake_pulse <= 1'b1;
    else stop_enter_pulse <= 1'b1;
    @(posedge clk);
    stop_wake_pulse  <= 1'b0;
    stop_enter_pulse <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic wait_pulse(input bit res, input int lim);
    int n0, n;
    n0 = res ? res_n : irq_n;
    n = 0;
    while ((res ? res_n : irq_n) == n0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < lim), 32'h1);
  endtask : wait_pulse
  task automatic run_sw(input logic src, input logic [1:0] div);
    logic [31:0] b;
    b = src ? 32'h2 : 32'h1;
    wr(WU_ADDR_CTRL, {29'h0, div, src});
    wr(WU_ADDR_SYS2, sys2 & ~b);
    sys2 = sys2 | b;
    wr(WU_ADDR_SYS2, sys2);
    e0 = src ? se : fe;
    wait_pulse(1'b0, 8000);
    near((src ? se : fe) - e0, 64 << div);
    rdchk(WU_ADDR_STATUS, 32'h0001_0000);
    $display("software warm-up test done");
  endtask : run_sw
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    chk({29'h0, cpu_periph_reset, fast_osc_run, slow_osc_run}, 32'h6);
    rdchk(WU_ADDR_CTRL, 32'h6);
    rdchk(WU_ADDR_CMP, 32'h66);
    rdchk(WU_ADDR_SYS2, 32'h1);
    rdchk(4'h1, 32'h0);
    wr(WU_ADDR_CMP, 32'h1);
    $display("reset values test done");
  endtask : t_reset
  task automatic t_por;
    int n;
    n = 0;
    while (cpu_periph_reset !== 1'b0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 9000), 32'h1);
    chk(32'(irq_n), 32'h0);
    bus(1'b0, WU_ADDR_STATUS, 32'h0);
    v = rd;
    chk(v & 32'hFFFF_0000, 32'h0001_0000);
    repeat (100) @(posedge clk);
    rdchk(WU_ADDR_STATUS, v);
    $display("power-on warm-up test done");
  endtask : t_por
  task automatic t_abort;
    wr(WU_ADDR_CTRL, 32'h1);
    wr(WU_ADDR_SYS2, sys2 & ~32'h2);
    wr(WU_ADDR_SYS2, sys2);
    repeat (40) @(posedge clk);
    i0 = irq_n;
    wr(WU_ADDR_CTRL, 32'h9);
    rdchk(WU_ADDR_CTRL, 32'h1);
    rdchk(WU_ADDR_STATUS, 32'h0001_0000);
    rdchk(WU_ADDR_SYS2, sys2);
    wr(WU_ADDR_SYS2, sys2);
    repeat (800) @(posedge clk);
    chk(32'(irq_n - i0), 32'h0);
    $display("abort test done");
  endtask : t_abort
  task automatic t_stop;
    wr(WU_ADDR_CTRL, 32'h0);
    main_clk_is_slow <= 1'b1;
    pulse(1'b0);
    repeat (4) @(posedge clk);
    chk({30'h0, fast_osc_run, slow_osc_run}, 32'h0);
    repeat (50) @(posedge clk);
    i0 = irq_n;
    e0 = se;
    pulse(1'b1);
    wait_pulse(1'b1, 4000);
    near(se - e0, 64);
    chk(32'(irq_n - i0), 32'h0);
    $display("stop release test done");
  endtask : t_stop
  task automatic t_frozen;
    main_clk_is_slow <= 1'b0;
    wr(WU_ADDR_CMP, 32'h2);
    wr(WU_ADDR_SYS2, 32'h2);
    wr(WU_ADDR_SYS2, 32'h3);
    repeat (100) @(posedge clk);
    pulse(1'b0);
    bus(1'b0, WU_ADDR_STATUS, 32'h0);
    v = rd;
    chk(v & 32'h0007_0000, 32'h0004_0000);
    repeat (200) @(posedge clk);
    rdchk(WU_ADDR_STATUS, v);
    i0 = irq_n;
    e0 = fe;
    pulse(1'b1);
    wait_pulse(1'b1, 4000);
    near(fe - e0, 128 - int'(v[13:0]));
    chk(32'(irq_n - i0), 32'h0);
    $display("frozen count test done");
  endtask : t_frozen

  initial begin
    // signals that the clocked block or tasks drive by NBA start by NBA too
    {fast_osc_clock, slow_osc_clock, ph} <= '0;
    {stop_enter_pulse, stop_wake_pulse, main_clk_is_slow} <= '0;
    {avs_address, avs_read, avs_write, avs_writedata} <= '0;
    avs_byteenable <= 4'hF;
    {fe, se, irq_n, res_n, cyc} <= '0;
    {bad_count, checks_done} = '0;
    sys2 = 32'h1;
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_por();
    for (int d = 0; d < 4; d++) run_sw(1'b0, 2'(d));
    run_sw(1'b1, 2'h0);
    t_abort();
    t_stop();
    t_frozen();
    finish_test();
  end
endmodule : tb
`default_nettype wire

// [dv/wu_checker.sv]
// Purpose: port checks for the oscillator warm-up counter
// Assumes: one clk domain, srst synchronous active high
// Notes:   bound to every wu_warmup_counter instance
`timescale 1ns/10ps
`default_nettype none
module wu_checker
  import wu_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  // results
  input wire logic        cpu_periph_reset,
  input wire logic        stop_resume_pulse,
  input wire logic        warmup_done_irq,
  input wire logic        fast_osc_run,
  input wire logic        slow_osc_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ****************
  // steps of a write
  // ****************
  sequence s_wr_done;
    avs_write && !avs_waitrequest && avs_byteenable[0];
  endsequence
  sequence s_abort_wr;
    s_wr_done ##0 (avs_address == WU_ADDR_CTRL
      && avs_writedata[WU_CTRL_ABORT_BIT]);
  endsequence
  sequence s_slow_start;
    s_wr_done ##0 (avs_address == WU_ADDR_SYS2
      && avs_writedata[WU_SYS2_SLOW_BIT] && !slow_osc_run
      && !cpu_periph_reset);
  endsequence
  a_reset_values: assert property ($fell(srst) |-> cpu_periph_reset
    && fast_osc_run && !slow_osc_run && !warmup_done_irq)
    else $error("wrong output levels after reset");
  a_cpu_rst_stays: assert property (!cpu_periph_reset |=> !cpu_periph_reset)
    else $error("cpu reset came back");
  a_irq_one_cycle: assert property (warmup_done_irq |=> !warmup_done_irq)
    else $error("irq longer than one cycle");
  a_resume_one_cycle: assert property (stop_resume_pulse |=> !stop_resume_pulse)
    else $error("resume longer than one cycle");
  a_no_pulse_por: assert property (cpu_periph_reset |-> !warmup_done_irq
    && !stop_resume_pulse) else $error("pulse during power-on warm-up");
  a_irq_resume_apart: assert property (warmup_done_irq |-> !stop_resume_pulse)
    else $error("irq together with resume");
  a_abort_keeps_en: assert property (s_abort_wr |=> $stable(fast_osc_run)
    && $stable(slow_osc_run)) else $error("abort changed an enable");
  a_slow_start: assert property (s_slow_start |-> ##[1:2] slow_osc_run)
    else $error("slow oscillator not started");
endmodule : wu_checker
bind wu_warmup_counter wu_checker u_chk (.clk(clk), .srst(srst),
  .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .cpu_periph_reset(cpu_periph_reset),
  .stop_resume_pulse(stop_resume_pulse), .warmup_done_irq(warmup_done_irq),
  .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run));
`default_nettype wire

// [rtl/wu_edge_sync.sv]
// Purpose: bring an oscillator pin into the clk domain, flag rising edges
// Assumes: pin toggles at less than half the rate of clk
// Notes:   first stage feeds only the second stage

`timescale 1ns/10ps
`default_nettype none

module wu_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // pin side
  input  wire logic pin_in,
  // clk side
  output var  logic rise_pulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r     <= 1'b0;
      sync_r     <= 1'b0;
      prev_r     <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      meta_r     <= pin_in;
      sync_r     <= meta_r;
      prev_r     <= sync_r;
      rise_pulse <= sync_r & ~prev_r;
    end
  end

endmodule : wu_edge_sync

`default_nettype wire

// [rtl/wu_pkg.sv]
// Purpose: constants shared by the oscillator warm-up counter block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   register offsets and field positions live here only

package wu_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] WU_ADDR_CTRL   = 4'h0;  // warmup_control_reg
  localparam logic [3:0] WU_ADDR_CMP    = 4'h4;  // warmup_compare_value
  localparam logic [3:0] WU_ADDR_SYS2   = 4'h8;  // system_control_two
  localparam logic [3:0] WU_ADDR_STATUS = 4'hC;  // live counter state

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int WU_CTRL_SRC_BIT   = 0;   // warmup_source_select
  localparam int WU_CTRL_DIV_LSB   = 1;   // warmup_divider_select [2:1]
  localparam int WU_CTRL_ABORT_BIT = 3;   // warmup_abort, self clearing
  localparam int WU_SYS2_FAST_BIT  = 0;   // fast_osc_enable
  localparam int WU_SYS2_SLOW_BIT  = 1;   // slow_osc_enable
  localparam int WU_STAT_STATE_LSB = 16;  // state code [18:16]
  localparam int WU_STAT_CPURST_BIT = 20; // cpu/peripheral reset held

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic       WU_SRC_RST      = 1'b0;
  localparam logic [1:0] WU_DIV_RST      = 2'h3;
  localparam logic [7:0] WU_CMP_RST      = 8'h66;
  localparam logic       WU_FAST_EN_RST  = 1'b1;
  localparam logic       WU_SLOW_EN_RST  = 1'b0;

  // ****************************************************************
  // divider select codes
  // ****************************************************************
  localparam logic [1:0] WU_DIV_1 = 2'h0;
  localparam logic [1:0] WU_DIV_2 = 2'h1;
  localparam logic [1:0] WU_DIV_4 = 2'h2;
  localparam logic [1:0] WU_DIV_8 = 2'h3;

  // ****************************************************************
  // control states
  // ****************************************************************
  typedef enum logic [2:0] {
    WU_ST_POR       = 3'b000,  // power-on warm-up, cpu held in reset
    WU_ST_IDLE      = 3'b001,
    WU_ST_SW        = 3'b010,  // software-started warm-up
    WU_ST_STOP      = 3'b011,  // stop mode, nothing was counting
    WU_ST_FROZEN    = 3'b100,  // stop mode, software count held
    WU_ST_STOP_WARM = 3'b101   // warm-up after stop release
  } wu_state_t;

endpackage : wu_pkg

// [rtl/wu_warmup_counter.sv]
// Purpose: oscillator warm-up counter with Avalon-MM register slave
// Assumes: oscillator pins slower than clk/2; stop entry/wake from the
//          mode controller on clk
// Notes:   counter advances on sampled oscillator edges
//
// Overview of operation
// - after srst release count warm-up while cpu and peripherals stay reset
// - reset sets source select 0 and divider select 11
// - after reset the fourteen-stage counter counts the fast oscillator
// - power-on: upper 8 bits match compare value, stop and release cpu reset
// - compare value resets to 0x66
// - stop release counts the oscillator that drove main clock at stop
// - after stop release count; on match stop and resume execution
// - divider select codes 00..11 divide by 1, 2, 4, 8
// - stop during software warm-up freezes count, continues after release
// - software warm-up uses fast clock for select 0, slow for 1
// - setting an oscillator enable starts oscillator and counter
// - only a 0-to-1 enable transition starts counting
// - software warm-up match raises interrupt, stops and clears counter
// - abort halts count, clears counter, abort bit returns to 0
// - abort leaves both oscillator enables unchanged
// - source selector, three-stage divider, fourteen-stage counter
//
// The Avalon-MM slave port and the address map were left to the implementer.

`timescale 1ns/10ps
`default_nettype none

module wu_warmup_counter
  import wu_pkg::*;
#(
  parameter int CNT_W = 14,
  parameter int CMP_W = 8,
  parameter int DIV_W = 3
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // oscillator pins
  input  wire logic        fast_osc_clock,
  input  wire logic        slow_osc_clock,
  // mode controller
  input  wire logic        stop_enter_pulse,
  input  wire logic        stop_wake_pulse,
  input  wire logic        main_clk_is_slow,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // results
  output var  logic        cpu_periph_reset,
  output var  logic        stop_resume_pulse,
  output var  logic        warmup_done_irq,
  output var  logic        fast_osc_run,
  output var  logic        slow_osc_run
);

  // ****************************************************************
  // oscillator edge capture
  // ****************************************************************
  logic fast_tick;
  logic slow_tick;

  wu_edge_sync u_fast_sync (
    .clk        (clk),
    .srst       (srst),
    .pin_in     (fast_osc_clock),
    .rise_pulse (fast_tick)
  );

  wu_edge_sync u_slow_sync (
    .clk        (clk),
    .srst       (srst),
    .pin_in     (slow_osc_clock),
    .rise_pulse (slow_tick)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  wu_state_t          state_r;
  wu_state_t          state_nxt;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [DIV_W-1:0]   div_r;
  logic [DIV_W-1:0]   div_nxt;
  logic               src_sel_r;
  logic [1:0]         div_sel_r;
  logic [CMP_W-1:0]   cmp_r;
  logic               fast_en_r;
  logic               slow_en_r;
  logic               stop_src_r;
  logic               stop_src_nxt;
  logic               cpu_rst_nxt;
  logic               irq_nxt;
  logic               resume_nxt;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire bus_req    = avs_read | avs_write;
  wire bus_take   = bus_req & ~avs_waitrequest;
  wire wr_take    = bus_take & avs_write & avs_byteenable[0];
  wire sel_ctrl   = (avs_address == WU_ADDR_CTRL);
  wire sel_cmp    = (avs_address == WU_ADDR_CMP);
  wire sel_sys2   = (avs_address == WU_ADDR_SYS2);
  wire sel_status = (avs_address == WU_ADDR_STATUS);
  wire wr_ctrl    = wr_take & sel_ctrl;
  wire wr_cmp     = wr_take & sel_cmp;
  wire wr_sys2    = wr_take & sel_sys2;

  wire wd_fast = avs_writedata[WU_SYS2_FAST_BIT];
  wire wd_slow = avs_writedata[WU_SYS2_SLOW_BIT];

  // abort is a write strobe only; the stored bit never reads as 1
  wire abort_req = wr_ctrl & avs_writedata[WU_CTRL_ABORT_BIT];

  // an enable that already holds 1 starts nothing
  wire start_edge = wr_sys2 &
                    ((wd_fast & ~fast_en_r) |
                     (wd_slow & ~slow_en_r));

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_word[WU_CTRL_SRC_BIT]                 = src_sel_r;
      rd_word[WU_CTRL_DIV_LSB +: 2]            = div_sel_r;
    end else if (sel_cmp) begin
      rd_word[CMP_W-1:0]                       = cmp_r;
    end else if (sel_sys2) begin
      rd_word[WU_SYS2_FAST_BIT]                = fast_en_r;
      rd_word[WU_SYS2_SLOW_BIT]                = slow_en_r;
    end else if (sel_status) begin
      rd_word[CNT_W-1:0]                       = cnt_r;
      rd_word[WU_STAT_STATE_LSB +: 3]          = state_r;
      rd_word[WU_STAT_CPURST_BIT]              = cpu_periph_reset;
    end
  end

  // ****************************************************************
  // source selection and three-stage divider
  // ****************************************************************
  // stop warm-up follows the clock captured at stop entry, not the select
  wire use_slow = (state_r == WU_ST_STOP_WARM) ? stop_src_r
                                               : src_sel_r;
  wire src_tick = use_slow ? slow_tick : fast_tick;

  wire counting = (state_r == WU_ST_POR) |
                  (state_r == WU_ST_SW)  |
                  (state_r == WU_ST_STOP_WARM);

  wire div_tick = (div_sel_r == WU_DIV_1) ? src_tick :
                  (div_sel_r == WU_DIV_2) ? src_tick & div_r[0] :
                  (div_sel_r == WU_DIV_4) ? src_tick & (&div_r[1:0]) :
                                            src_tick & (&div_r);

  // only the upper bits are compared, so one step is 2^6 counter inputs
  wire match = (cnt_r[CNT_W-1 -: CMP_W] == cmp_r);

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    div_nxt      = div_r;
    stop_src_nxt = stop_src_r;
    cpu_rst_nxt  = cpu_periph_reset;
    irq_nxt      = 1'b0;
    resume_nxt   = 1'b0;
    if (counting && src_tick) begin
      div_nxt = div_r + 1'b1;
    end
    if (counting && div_tick) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    case (state_r)
      WU_ST_POR: begin
        if (match) begin
          state_nxt   = WU_ST_IDLE;
          cpu_rst_nxt = 1'b0;
          cnt_nxt     = '0;
          div_nxt     = '0;
        end
      end
      WU_ST_IDLE: begin
        if (stop_enter_pulse) begin
          state_nxt    = WU_ST_STOP;
          stop_src_nxt = main_clk_is_slow;
        end else if (start_edge) begin
          state_nxt = WU_ST_SW;
          cnt_nxt   = '0;
          div_nxt   = '0;
        end
      end
      WU_ST_SW: begin
        if (abort_req) begin
          state_nxt = WU_ST_IDLE;
          cnt_nxt   = '0;
          div_nxt   = '0;
        end else if (match) begin
          state_nxt = WU_ST_IDLE;
          irq_nxt   = 1'b1;
          cnt_nxt   = '0;
          div_nxt   = '0;
        end else if (stop_enter_pulse) begin
          // count is held as it is; the later stop warm-up starts from it
          state_nxt    = WU_ST_FROZEN;
          stop_src_nxt = main_clk_is_slow;
          cnt_nxt      = cnt_r;
          div_nxt      = div_r;
        end
      end
      WU_ST_STOP: begin
        if (stop_wake_pulse) begin
          state_nxt = WU_ST_STOP_WARM;
          cnt_nxt   = '0;
          div_nxt   = '0;
        end
      end
      WU_ST_FROZEN: begin
        if (stop_wake_pulse) begin
          state_nxt = WU_ST_STOP_WARM;
        end
      end
      WU_ST_STOP_WARM: begin
        if (match) begin
          state_nxt  = WU_ST_IDLE;
          resume_nxt = 1'b1;
          cnt_nxt    = '0;
          div_nxt    = '0;
        end
      end
      default: begin
        state_nxt = WU_ST_IDLE;
        cnt_nxt   = '0;
        div_nxt   = '0;
      end
    endcase
  end

  // ****************************************************************
  // counter state registers
  // ****************************************************************
  // srst clears the counter at once and puts the cpu side in reset
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r          <= WU_ST_POR;
      cnt_r            <= '0;
      div_r            <= '0;
      stop_src_r       <= 1'b0;
      cpu_periph_reset <= 1'b1;
    end else begin
      state_r          <= state_nxt;
      cnt_r            <= cnt_nxt;
      div_r            <= div_nxt;
      stop_src_r       <= stop_src_nxt;
      cpu_periph_reset <= cpu_rst_nxt;
    end
  end

  // ****************************************************************
  // event outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      warmup_done_irq   <= 1'b0;
      stop_resume_pulse <= 1'b0;
    end else begin
      warmup_done_irq   <= irq_nxt;
      stop_resume_pulse <= resume_nxt;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      src_sel_r <= WU_SRC_RST;
      div_sel_r <= WU_DIV_RST;
      cmp_r     <= WU_CMP_RST;
    end else begin
      if (wr_ctrl) begin
        src_sel_r <= avs_writedata[WU_CTRL_SRC_BIT];
        div_sel_r <= avs_writedata[WU_CTRL_DIV_LSB +: 2];
      end
      if (wr_cmp) begin
        cmp_r <= avs_writedata[CMP_W-1:0];
      end
    end
  end

  // abort never touches the enables; only sys2 writes move them
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_en_r <= WU_FAST_EN_RST;
      slow_en_r <= WU_SLOW_EN_RST;
    end else if (wr_sys2) begin
      fast_en_r <= wd_fast;
      slow_en_r <= wd_slow;
    end
  end

  // ****************************************************************
  // oscillator run outputs
  // ****************************************************************
  // both oscillators are halted while stop mode lasts
  wire in_stop = (state_r == WU_ST_STOP) | (state_r == WU_ST_FROZEN);

  always_ff @(posedge clk) begin
    if (srst) begin
      fast_osc_run <= WU_FAST_EN_RST;
      slow_osc_run <= WU_SLOW_EN_RST;
    end else begin
      fast_osc_run <= fast_en_r & ~in_stop;
      slow_osc_run <= slow_en_r & ~in_stop;
    end
  end

  // ****************************************************************
  // Avalon-MM handshake
  // ****************************************************************
  // one wait cycle per access: data is registered while waitrequest is
  // high, and the access completes in the following low cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_word;
      end
    end
  end

endmodule : wu_warmup_counter

`default_nettype wire
